// File: design/sgp_consts.vh
// Constants for the scratch register bank and its reset-state logic
`ifndef SGP_CONSTS_VH
`define SGP_CONSTS_VH
`define SGP_FRAME_W        16
`define SGP_DATA_W         12
`define SGP_SEL_HI         15
`define SGP_SEL_LO         14
`define SGP_RBSEL_BIT      13
`define SGP_NOWR_BIT       12
`define SGP_IDFLAG_BIT     11
`define SGP_SEL_SCR0       2'h2
`define SGP_SEL_SCR1       2'h3
`define SGP_SEL_SPECIAL    2'h1
`define SGP_SCR1_RESET     12'h000
`define SGP_TYPE_W         7
`define SGP_VER_W          4
`define SGP_CAUSE_POWERON  4'h0
`define SGP_CAUSE_STARTUP_BAD 4'hC
`define SGP_BUS_FAIL_OK    4'h0
`define SGP_ERROR_EMULATION_MODE_BIT      8
`define SGP_RST_NONE       2'h0
`define SGP_RST_POWERON    2'h1
`define SGP_RST_STARTUP    2'h2
`define SGP_RST_RESTART    2'h3
`endif

// File: design/sgp_frame_rx.v
// Serial frame shifter: collects a 16-bit command and shifts out a 12-bit answer
`include "sgp_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module sgp_frame_rx (
  input  wire        clk_sys,    // System clock
  input  wire        rstn,       // Async reset, active low
  input  wire        sel_n,      // Frame select, active low
  input  wire        sclk,       // Serial clock level, sampled
  input  wire        sdi,        // Serial data in
  input  wire [11:0] answer,     // Readback word for this frame
  output reg         sdo,        // Serial data out
  output reg         cmd_valid,  // One-cycle pulse, command complete
  output reg  [15:0] cmd         // Captured command word
);
  reg  [15:0] shreg;
  reg  [11:0] outreg;
  reg  [4:0]  bitcnt;
  reg         sclk_d;
  reg         cmd_seen;
  wire        rise = sclk & ~sclk_d & ~sel_n;
  wire        fall = ~sclk & sclk_d & ~sel_n;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shreg     <= 16'h0000;
      outreg    <= 12'h000;
      bitcnt    <= 5'h00;
      sclk_d    <= 1'b0;
      sdo       <= 1'b0;
      cmd_valid <= 1'b0;
      cmd       <= 16'h0000;
      cmd_seen  <= 1'b0;
    end else begin
      sclk_d    <= sclk;
      cmd_valid <= 1'b0;
      if (sel_n) begin
        bitcnt   <= 5'h00;
        cmd_seen <= 1'b0;
        sdo      <= 1'b0;
      end else begin
        if (rise) begin
          shreg  <= {shreg[14:0], sdi};
          bitcnt <= bitcnt + 5'h01;
          // Once bits 15..12 are in, the answer is loaded for the low 12 bits
          if (bitcnt == 5'h03) begin
            outreg <= answer;
          end
          if (bitcnt == 5'h0F && !cmd_seen) begin
            cmd       <= {shreg[14:0], sdi};
            cmd_valid <= 1'b1;
            cmd_seen  <= 1'b1;
          end
        end
        if (fall && bitcnt >= 5'h04 && bitcnt < 5'h10) begin
          sdo    <= outreg[11];
          outreg <= {outreg[10:0], 1'b0};
        end
      end
    end
  end
endmodule // sgp_frame_rx
`default_nettype wire

// File: design/sgp_reset_state.v
// Reset-cause tracking for wake flags, interrupt enables and pending interrupts
`include "sgp_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module sgp_reset_state (
  input  wire       clk_sys,     // System clock
  input  wire       rstn,        // Async reset, active low
  input  wire [1:0] rst_event,   // Reset kind, one-cycle
  input  wire [2:0] wake_src,    // Bus, local bus, pin edge wake causes
  input  wire [2:0] wake_set,    // Live wake events
  input  wire [7:0] irq_en_wr,   // Interrupt enable write data
  input  wire       irq_en_we,   // Interrupt enable write strobe
  input  wire [7:0] irq_evt,     // Interrupt events
  input  wire [7:0] irq_clr,     // Interrupt clear mask
  output reg  [2:0] wake_flags,  // Bus, local bus, pin edge flags
  output reg  [7:0] irq_en,      // Interrupt enables
  output reg  [7:0] irq_pend     // Pending interrupts
);
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_flags <= 3'h0;
      irq_en     <= 8'h00;
      irq_pend   <= 8'h00;
    end else begin
      case (rst_event)
        `SGP_RST_POWERON: begin
          wake_flags <= 3'h0;
          irq_en     <= 8'h00;
          irq_pend   <= 8'h00;
        end
        `SGP_RST_STARTUP: begin
          wake_flags <= wake_flags | wake_src;
          irq_pend   <= 8'h00;
        end
        `SGP_RST_RESTART: begin
          irq_pend   <= 8'h00;
        end
        default: begin
          wake_flags <= wake_flags | wake_set;
          if (irq_en_we) begin
            irq_en <= irq_en_wr;
          end
          irq_pend <= (irq_pend & ~irq_clr) | (irq_evt & irq_en);
        end
      endcase
    end
  end
endmodule // sgp_reset_state
`default_nettype wire

// File: design/sgp_regs.v
// Scratch register bank with identity code, readback muxing and reset-state status
//
// Functional notes
// - Two 12-bit scratch registers, each readable back through the serial answer.
// - Power-up loads register zero with identity code and clears identity flag.
// - Any write to register zero sets identity flag bit 11 regardless.
// - Identity flag reads 1 for user content, 0 for identity code.
// - Select code 10 addresses register zero, 11 addresses register one.
// - Register zero access: readback select 1 gives it, 0 system configuration.
// - Register one access: readback select 1 gives it, 0 physical layer.
// - No-write bit 1 only reads; 0 reads and writes the register.
// - Register zero bits 10..0 and register one bits 11..0 store freely.
// - Reset cause 0000 at power-on, never 1100 at start-up.
// - Wake flags cleared at power-on, set by cause at start-up, kept otherwise.
// - Enable status 0 after reset unless error emulation shows no bus failure.
// - Diagnosis fields take fixed power-on values, live values otherwise.
// - Interrupt enables cleared at power-on, kept through start-up and restart.
// - Pending interrupts cleared at every reset kind.
`include "sgp_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module sgp_regs #(
  parameter [6:0] CHIP_TYPE    = 7'h55,  // Arbitrary value
  parameter [3:0] CHIP_VERSION = 4'hA    // Arbitrary value
) (
  input  wire        clk_sys,          // System clock 25 MHz
  input  wire        rstn,             // Async reset, active low
  input  wire        sel_n,            // Serial frame select, active low
  input  wire        sclk,             // Serial clock
  input  wire        sdi,              // Serial data in
  input  wire [1:0]  rst_event,        // Reset kind pulse: 1 power-on, 2 start-up, 3 restart
  input  wire [3:0]  rst_cause_in,     // Cause code for start-up or restart
  input  wire [2:0]  wake_src,         // Wake sources that caused start-up
  input  wire [2:0]  wake_set,         // Live wake events
  input  wire [11:0] sys_cfg_fb,       // System configuration feedback
  input  wire [11:0] phy_ctl_fb,       // Physical layer control feedback
  input  wire [11:0] special_fb,       // Special mode feedback
  input  wire [7:0]  irq_en_wr,        // Interrupt enable write data
  input  wire        irq_en_we,        // Interrupt enable write strobe
  input  wire [7:0]  irq_evt,          // Interrupt events
  input  wire [7:0]  irq_clr,          // Interrupt clear mask
  input  wire        ground_shift_in,  // Live ground shift status
  input  wire [3:0]  bus_fail_in,      // Live bus failure status
  input  wire [1:0]  local_fail_in,    // Live local bus failure status
  input  wire [2:0]  supply_in,        // Live supply three, two, one status
  input  wire [1:0]  bus_mode_in,      // Live bus mode status
  output reg         sdo,              // Serial data out
  output reg         identity_flag,    // Register zero holds user content
  output reg  [11:0] scratch_register_zero, // Scratch register zero
  output reg  [11:0] scratch_register_one,  // Scratch register one
  output reg  [3:0]  reset_cause_field,     // Reset cause
  output reg  [2:0]  wake_flags,       // Bus, local bus, pin edge wake flags
  output reg         enable_status_flag,    // Enable status
  output reg         ground_shift_diag,     // Ground shift diagnosis
  output reg  [3:0]  bus_failure_diag,      // Bus failure diagnosis
  output reg  [1:0]  local_bus_failure_diag, // Local bus failure diagnosis
  output reg  [2:0]  supply_diag,      // Supply three, two, one diagnosis
  output reg  [1:0]  bus_mode_diag,    // Bus mode diagnosis
  output reg  [7:0]  irq_en,           // Interrupt enables
  output reg  [7:0]  irq_pend          // Pending interrupts
);
  function [11:0] sgp_answer;
    input [1:0]  code;
    input        rbsel;
    input [11:0] s0;
    input [11:0] s1;
    input [11:0] cfg;
    input [11:0] phy;
    input [11:0] spc;
    begin
      case (code)
        `SGP_SEL_SCR0: sgp_answer = rbsel ? s0 : cfg;
        `SGP_SEL_SCR1: sgp_answer = rbsel ? s1 : phy;
        `SGP_SEL_SPECIAL: sgp_answer = rbsel ? spc : 12'h000;
        default: sgp_answer = 12'h000;
      endcase
    end
  endfunction

  wire [15:0] cmd;
  wire        cmd_valid;
  wire        rx_sdo;
  wire [2:0]  rs_wake;
  wire [7:0]  rs_en;
  wire [7:0]  rs_pend;
  reg  [15:0] head;
  reg         sclk_d;
  reg         error_emulation_mode;
  wire [11:0] answer;
  wire        rise = sclk & ~sclk_d & ~sel_n;

  // Header bits are tracked here too so the answer is ready inside the frame
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      head   <= 16'h0000;
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk;
      if (rise) begin
        head <= {head[14:0], sdi};
      end
    end
  end

  // Loaded on the 4th rise, when head[2:0] holds select code and readback select
  assign answer = sgp_answer(head[2:1], head[0], scratch_register_zero,
                             scratch_register_one, sys_cfg_fb, phy_ctl_fb,
                             special_fb);

  sgp_frame_rx u_rx (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .sel_n     (sel_n),
    .sclk      (sclk),
    .sdi       (sdi),
    .answer    (answer),
    .sdo       (rx_sdo),
    .cmd_valid (cmd_valid),
    .cmd       (cmd)
  );

  sgp_reset_state u_rs (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .rst_event  (rst_event),
    .wake_src   (wake_src),
    .wake_set   (wake_set),
    .irq_en_wr  (irq_en_wr),
    .irq_en_we  (irq_en_we),
    .irq_evt    (irq_evt),
    .irq_clr    (irq_clr),
    .wake_flags (rs_wake),
    .irq_en     (rs_en),
    .irq_pend   (rs_pend)
  );

  wire wr_en   = cmd_valid & ~cmd[`SGP_NOWR_BIT];
  wire [1:0] code = cmd[`SGP_SEL_HI:`SGP_SEL_LO];

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scratch_register_zero  <= 12'h000;
      scratch_register_one   <= `SGP_SCR1_RESET;
      identity_flag          <= 1'b0;
      reset_cause_field      <= `SGP_CAUSE_POWERON;
      enable_status_flag     <= 1'b0;
      error_emulation_mode   <= 1'b0;
      ground_shift_diag      <= 1'b0;
      bus_failure_diag       <= `SGP_BUS_FAIL_OK;
      local_bus_failure_diag <= 2'h0;
      supply_diag            <= 3'h6;
      bus_mode_diag          <= 2'h0;
      sdo                    <= 1'b0;
      wake_flags             <= 3'h0;
      irq_en                 <= 8'h00;
      irq_pend               <= 8'h00;
    end else begin
      sdo        <= rx_sdo;
      wake_flags <= rs_wake;
      irq_en     <= rs_en;
      irq_pend   <= rs_pend;
      if (rst_event == `SGP_RST_POWERON) begin
        // Identity code: version in 10..7, chip type in 6..0
        scratch_register_zero  <= {1'b0, CHIP_VERSION, CHIP_TYPE};
        identity_flag          <= 1'b0;
        scratch_register_one   <= `SGP_SCR1_RESET;
        reset_cause_field      <= `SGP_CAUSE_POWERON;
        error_emulation_mode   <= 1'b0;
        enable_status_flag     <= 1'b0;
        ground_shift_diag      <= 1'b0;
        bus_failure_diag       <= `SGP_BUS_FAIL_OK;
        local_bus_failure_diag <= 2'h0;
        supply_diag            <= 3'h6;
        bus_mode_diag          <= 2'h0;
      end else begin
        if (rst_event == `SGP_RST_STARTUP) begin
          // Forbidden start-up code falls back to power-on
          reset_cause_field <= (rst_cause_in == `SGP_CAUSE_STARTUP_BAD) ?
                               `SGP_CAUSE_POWERON : rst_cause_in;
        end else if (rst_event == `SGP_RST_RESTART) begin
          reset_cause_field <= rst_cause_in;
        end
        if (rst_event != `SGP_RST_NONE) begin
          enable_status_flag <= error_emulation_mode &
                                (bus_fail_in == `SGP_BUS_FAIL_OK);
        end else if (error_emulation_mode) begin
          enable_status_flag <= (bus_fail_in == `SGP_BUS_FAIL_OK);
        end
        ground_shift_diag      <= ground_shift_in;
        bus_failure_diag       <= bus_fail_in;
        local_bus_failure_diag <= local_fail_in;
        supply_diag            <= supply_in;
        bus_mode_diag          <= bus_mode_in;
        if (wr_en && code == `SGP_SEL_SCR0) begin
          scratch_register_zero <= {1'b1, cmd[10:0]};
          identity_flag         <= 1'b1;
        end
        if (wr_en && code == `SGP_SEL_SCR1) begin
          scratch_register_one <= cmd[11:0];
        end
        if (wr_en && code == `SGP_SEL_SPECIAL) begin
          error_emulation_mode <= cmd[`SGP_ERROR_EMULATION_MODE_BIT];
        end
      end
    end
  end
  // Bit 11 of register zero mirrors the identity flag
endmodule // sgp_regs
`default_nettype wire

// File: verif/sgp_regs_props.sv
// Port assertions for the scratch register bank
`timescale 1ns/100ps
`default_nettype none
module sgp_regs_props #(
  parameter [6:0] CHIP_TYPE    = 7'h55, // Arbitrary value
  parameter [3:0] CHIP_VERSION = 4'hA   // Arbitrary value
) (
  input wire logic        clk_sys,               // System clock
  input wire logic        rstn,                  // Async reset, active low
  input wire logic        sel_n,                 // Frame select
  input wire logic [1:0]  rst_event,             // Reset kind
  input wire logic [2:0]  wake_src,              // Start-up causes
  input wire logic [2:0]  wake_set,              // Live wake events
  input wire logic        irq_en_we,             // Enable write strobe
  input wire logic [7:0]  irq_evt,               // Interrupt events
  input wire logic        identity_flag,         // Identity flag
  input wire logic [11:0] scratch_register_zero, // Scratch zero
  input wire logic [11:0] scratch_register_one,  // Scratch one
  input wire logic [3:0]  reset_cause_field,     // Reset cause
  input wire logic [2:0]  wake_flags,            // Wake flags
  input wire logic [7:0]  irq_en,                // Interrupt enables
  input wire logic [7:0]  irq_pend               // Pending interrupts
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_ID_LOAD: assert property (rst_event == 2'h1 |-> ##[1:2]
    scratch_register_zero == {1'b0, CHIP_VERSION, CHIP_TYPE}) else $error("id not loaded");
  AST_FLAG_TRACK: assert property ($stable(scratch_register_zero)[*3] |->
    identity_flag == scratch_register_zero[11]) else $error("flag mismatch");
  AST_ONE_WRITE: assert property ($changed(scratch_register_one) |-> !sel_n ||
    $past(rst_event) != 2'h0 || $past(rst_event, 2) != 2'h0) else $error("stray write");
  AST_CAUSE_PWR: assert property (rst_event == 2'h1 |-> ##[1:2]
    reset_cause_field == 4'h0) else $error("cause not cleared");
  AST_CAUSE_START: assert property (rst_event == 2'h2 |-> ##1 reset_cause_field != 4'hC
    ##1 reset_cause_field != 4'hC) else $error("bad start-up cause");
  AST_WAKE_START: assert property (rst_event == 2'h2 ##1 $stable(wake_src) |->
    ##[0:1] (wake_flags & wake_src) == wake_src) else $error("wake cause lost");
  AST_WAKE_PWR: assert property (rst_event == 2'h1 && wake_set == 3'h0 ##1 wake_set == 3'h0
    |-> ##[0:1] wake_flags == 3'h0) else $error("wake flags kept");
  AST_PEND_CLR: assert property (rst_event != 2'h0 && irq_evt == 8'h00 ##1 irq_evt == 8'h00
    |-> ##[0:1] irq_pend == 8'h00) else $error("pending kept");
  AST_EN_PWR: assert property (rst_event == 2'h1 && !irq_en_we ##1 !irq_en_we
    |-> ##[0:1] irq_en == 8'h00) else $error("enables kept");
  cover property (rst_event == 2'h3);
  cover property ($rose(identity_flag));
  cover property ($changed(scratch_register_one));
endmodule // sgp_regs_props
bind sgp_regs sgp_regs_props #(.CHIP_TYPE(CHIP_TYPE), .CHIP_VERSION(CHIP_VERSION)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .sel_n(sel_n), .rst_event(rst_event),
  .wake_src(wake_src), .wake_set(wake_set), .irq_en_we(irq_en_we), .irq_evt(irq_evt),
  .identity_flag(identity_flag), .scratch_register_zero(scratch_register_zero),
  .scratch_register_one(scratch_register_one), .reset_cause_field(reset_cause_field),
  .wake_flags(wake_flags), .irq_en(irq_en), .irq_pend(irq_pend));
`default_nettype wire

// File: verif/sgp_host.sv
// Host model driving serial frames into the register bank
`timescale 1ns/100ps
`default_nettype none
module sgp_host (
  input  wire logic clk_sys, // System clock
  output var  logic sel_n,   // Frame select, active low
  output var  logic sclk,    // Serial clock, still between frames
  output var  logic sdi,     // Serial data to device
  input  wire logic sdo      // Serial data from device
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  task automatic frame(input logic [15:0] cmd, output logic [11:0] ans);
    sel_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sclk = 1'b0;
      sdi = cmd[15 - i];
      repeat (4) @(posedge clk_sys);
      #1;
      if (i >= 4) ans[15 - i] = sdo;
      sclk = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
    end
    sclk = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 sel_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale data
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
endmodule // sgp_host
`default_nettype wire

// File: verif/sgp_regs_test.sv
// Self-checking bench for the scratch register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sgp_regs_test;
  localparam logic [6:0]  TYP = 7'h2B; // Arbitrary value
  localparam logic [3:0]  VER = 4'h6;  // Arbitrary value
  localparam logic [11:0] ID  = {1'b0, VER, TYP};
  logic        clk_sys = 0, rstn = 0, irq_en_we = 0, ground_shift_in = 0;
  logic [1:0]  rst_event = 0, local_fail_in = 0, bus_mode_in = 0;
  logic [3:0]  rst_cause_in = 0, bus_fail_in = 0, codes [4] = '{4'h0, 4'h2, 4'hC, 4'hE};
  logic [2:0]  wake_src = 0, wake_set = 0, supply_in = 0, kept;
  logic [11:0] sys_cfg_fb = 0, phy_ctl_fb = 0, special_fb = 0, m0, m1, ans;
  logic [7:0]  irq_en_wr = 0, irq_evt = 0, irq_clr = 0;
  logic [15:0] cmd;
  int          failures = 0, total_checks = 0, cyc = 0;
  wire         sel_n, sclk, sdi, sdo, identity_flag, enable_status_flag, ground_shift_diag;
  wire [11:0]  scratch_register_zero, scratch_register_one;
  wire [3:0]   reset_cause_field, bus_failure_diag;
  wire [2:0]   wake_flags, supply_diag;
  wire [1:0]   local_bus_failure_diag, bus_mode_diag;
  wire [7:0]   irq_en, irq_pend;
  sgp_regs #(.CHIP_TYPE(TYP), .CHIP_VERSION(VER)) i_sgp_regs (.clk_sys, .rstn, .sel_n,
    .sclk, .sdi, .rst_event, .rst_cause_in, .wake_src, .wake_set, .sys_cfg_fb, .phy_ctl_fb,
    .special_fb, .irq_en_wr, .irq_en_we, .irq_evt, .irq_clr, .ground_shift_in, .bus_fail_in,
    .local_fail_in, .supply_in, .bus_mode_in, .sdo, .identity_flag, .scratch_register_zero,
    .scratch_register_one, .reset_cause_field, .wake_flags, .enable_status_flag,
    .ground_shift_diag, .bus_failure_diag, .local_bus_failure_diag, .supply_diag,
    .bus_mode_diag, .irq_en, .irq_pend);
  sgp_host i_sgp_host (.clk_sys, .sel_n, .sclk, .sdi, .sdo);
  always #20 clk_sys = ~clk_sys;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input logic [1:0] k);
    rst_event = k;
    tick(1);
    rst_event = 2'h0;
    tick(3);
  endtask
  function automatic logic [11:0] expect_rb(input logic [15:0] c);
    case (c[15:14])
      2'h2: return c[13] ? m0 : sys_cfg_fb;
      2'h3: return c[13] ? m1 : phy_ctl_fb;
      2'h1: return c[13] ? special_fb : 12'h000;
      default: return 12'h000;
    endcase
  endfunction
  task automatic access(input logic [15:0] c);
    logic [11:0] e;
    e = expect_rb(c);
    i_sgp_host.frame(c, ans);
    `CHK(ans, e)
    if (!c[12] && c[15:14] == 2'h2) m0 = {1'b1, c[10:0]};
    if (!c[12] && c[15:14] == 2'h3) m1 = c[11:0];
    `CHK({scratch_register_zero, scratch_register_one, identity_flag}, {m0, m1, m0[11]})
  endtask
  task automatic close_out;
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    void'($urandom(32'hd781d1a9));
    {ground_shift_in, bus_fail_in, local_fail_in, supply_in, bus_mode_in} = $urandom | 1;
    tick(11);
    `CHK({ground_shift_diag, bus_failure_diag, local_bus_failure_diag, supply_diag, bus_mode_diag}, 12'h018)
    tick(1);
    rstn = 1'b1;
    tick(1);
    pulse(2'h1);
    m0 = ID;
    m1 = 12'h000;
    `CHK({scratch_register_zero, reset_cause_field, wake_flags, irq_en, irq_pend}, {ID, 23'h0})
    access(16'hB000 | 16'($urandom) & 16'h0FFF);
    for (int i = 0; i < 24; i++) begin
      {sys_cfg_fb, phy_ctl_fb, special_fb} = {$urandom, $urandom};
      cmd = $urandom | 16'h8000;
      if (i == 0) cmd = 16'h8000;
      access(cmd);
    end
    access(16'h3000);
    access(16'h7000);
    irq_en_wr = $urandom | 32'h80;
    irq_en_we = 1'b1;
    irq_evt = 8'h81;
    tick(1);
    irq_en_we = 1'b0;
    tick(1);
    irq_evt = 8'h80;
    irq_clr = 8'h81;
    tick(1);
    `CHK(irq_pend, 8'h81 & irq_en_wr)
    irq_evt = 8'h00;
    irq_clr = 8'h00;
    tick(2);
    `CHK(irq_pend, 8'h80)
    wake_src = $urandom;
    rst_cause_in = 4'hC;
    pulse(2'h2);
    `CHK({reset_cause_field, wake_flags, irq_en, irq_pend}, {4'h0, wake_src, irq_en_wr, 8'h00})
    `CHK({ground_shift_diag, bus_failure_diag, local_bus_failure_diag, supply_diag, bus_mode_diag}, {ground_shift_in, bus_fail_in, local_fail_in, supply_in, bus_mode_in})
    wake_set = 3'h7;
    tick(1);
    wake_set = 3'h0;
    tick(2);
    kept = 3'h7;
    foreach (codes[k]) begin
      rst_cause_in = codes[k];
      wake_src = ~wake_src;
      pulse(2'h3);
      `CHK({reset_cause_field, wake_flags, irq_en}, {codes[k], kept, irq_en_wr})
    end
    access(16'h4100);
    bus_fail_in = 4'h0;
    pulse(2'h3);
    `CHK(enable_status_flag, 1'b1)
    bus_fail_in = 4'h3;
    tick(3);
    `CHK(enable_status_flag, 1'b0)
    pulse(2'h1);
    `CHK({scratch_register_zero, identity_flag, wake_flags, irq_en}, {ID, 1'b0, 3'h0, 8'h00})
    close_out;
  end
endmodule // sgp_regs_test
`default_nettype wire
